// [tkd_pkg.sv]
// package of constants and types for the touch key detection logic
`default_nettype none

package tkd_pkg;

    // ------------------------------------------------------------------
    // channel and data sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH = 5;
    localparam int CH_W   = 3;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // signal processing constants
    // ------------------------------------------------------------------
    localparam logic signed [15:0] THRESHOLD     = 16'sh0006;
    localparam logic signed [15:0] HYSTERESIS    = 16'sh0002;
    localparam logic signed [15:0] RELEASE_LEVEL = THRESHOLD - HYSTERESIS;
    localparam logic [1:0]         INTEG_LIMIT   = 2'h3;
    localparam logic [7:0]         DRIFT_DOWN_SAMPLES = 8'h04;
    localparam logic [7:0]         DRIFT_UP_SAMPLES   = 8'h10;

    // ------------------------------------------------------------------
    // timing: figures are nominal at the reference clock, counts in clocks
    // ------------------------------------------------------------------
    localparam int REF_CLOCK_HZ    = 10_000_000;
    localparam int RESPONSE_MS     = 99;
    localparam int TIMEOUT_SHORT_S = 10;
    localparam int TIMEOUT_LONG_S  = 60;
    localparam int RESPONSE_CLOCKS      = RESPONSE_MS * (REF_CLOCK_HZ / 1000);
    localparam int ACQ_CYCLE_CLOCKS     = RESPONSE_CLOCKS / 3;
    localparam int TIMEOUT_SHORT_CLOCKS = TIMEOUT_SHORT_S * REF_CLOCK_HZ;
    localparam int TIMEOUT_LONG_CLOCKS  = TIMEOUT_LONG_S * REF_CLOCK_HZ;

    // ------------------------------------------------------------------
    // register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_OPTS     = 8'h08;
    localparam logic [7:0] ADDR_REF_BASE = 8'h10;
    localparam logic [7:0] ADDR_REF_LAST = 8'h20;
    localparam int STATUS_OUT_LSB   = 8;
    localparam int STATUS_RX_LSB    = 16;
    localparam int OPTS_MODE_LSB    = 0;
    localparam int OPTS_DRIVE_BIT   = 2;
    localparam int OPTS_STRONG_BIT  = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] RST_CAL_PENDING = 5'h1F;
    localparam logic [4:0] RST_RX_MASK     = 5'h1F;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        TKD_MODE_DC_INFINITE = 2'h0,
        TKD_MODE_DC_SHORT    = 2'h1,
        TKD_MODE_DC_LONG     = 2'h2,
        TKD_MODE_TOGGLE      = 2'h3
    } tkd_mode_type;

    typedef struct packed
    {
        logic              valid;
        logic [CH_W-1:0]   chan;
        logic [DATA_W-1:0] value;
    } tkd_sample_type;

    typedef struct packed
    {
        logic mode_strap_a;
        logic mode_strap_b;
        logic drive_type_strap;
        logic strongest_key_strap;
    } tkd_strap_type;

    typedef struct packed
    {
        logic [NUM_CH-1:0] level;
        logic [NUM_CH-1:0] oe;
    } tkd_pin_type;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } tkd_apb_req_type;

    typedef struct packed
    {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } tkd_apb_rsp_type;

    typedef struct packed
    {
        logic [NUM_CH-1:0][15:0] ref_level;
        logic [NUM_CH-1:0][15:0] delta;
        logic [NUM_CH-1:0][1:0]  integ;
        logic [NUM_CH-1:0][7:0]  drift_cnt;
        logic [NUM_CH-1:0][31:0] on_timer;
        logic [NUM_CH-1:0]       detected;
        logic [NUM_CH-1:0]       out_state;
        logic [NUM_CH-1:0]       cal_pending;
        logic [NUM_CH-1:0]       rx_mask;
        logic [31:0]             acq_timer;
        tkd_mode_type            mode;
        logic                    drive_open;
        logic                    strongest_en;
        logic                    acq_request;
        tkd_pin_type             pins;
        tkd_apb_rsp_type         apb;
    } tkd_state_type;

endpackage

`default_nettype wire

// [tkd_touch_key_detect.sv]
// touch key detection logic: drift tracking, threshold, integrator, timeout, outputs, apb registers
//
// Overview of operation
// - reference follows signal only without detection
// - slew-limited per-channel reference; thresholds relative to it
// - reference frozen while channel senses object
// - reference falls faster than it rises
// - all signal arithmetic is 16 bits
// - detect when signal exceeds reference by 6
// - release level sits 2 below threshold
// - detection timer forces recalibration on expiry
// - timeout straps select 10 s, 60 s, infinite
// - timeouts run independently per channel
// - timeouts are counted in device clocks
// - long bursts may stretch timeouts; here timeouts count clocks, so bursts do not stretch them
// - integrator needs three successive detecting samples
// - reset is active low and recalibrates all
// - response time 99 ms at 10 MHz, scaled
// - straps sampled once per acquisition cycle
// - mode and timeout straps are global
// - dc mode: active while detected, off on timeout
// - toggle mode: each detection inverts the output
// - toggle timeout 10 s, output kept
// - drive strap: push-pull high or open-drain low
// - mode strap pair encodes mode and timeout
// - suppression checks other keys before activating
// - suppression strap low disables, high enables
//
// Chosen here: the register offsets and register access over APB.
`default_nettype none

module tkd_touch_key_detect
#(
    parameter logic [31:0] TIMEOUT_SHORT = tkd_pkg::TIMEOUT_SHORT_CLOCKS,
    parameter logic [31:0] TIMEOUT_LONG  = tkd_pkg::TIMEOUT_LONG_CLOCKS,
    parameter logic [31:0] ACQ_CYCLE     = tkd_pkg::ACQ_CYCLE_CLOCKS
)
(
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // register bus
    input  wire tkd_pkg::tkd_apb_req_type apb_req,
    output var  tkd_pkg::tkd_apb_rsp_type apb_rsp,
    // acquisition front end
    output var  logic                     acq_request,
    input  wire tkd_pkg::tkd_sample_type  sample,
    // option straps
    input  wire tkd_pkg::tkd_strap_type   straps,
    // key output pins
    output var  tkd_pkg::tkd_pin_type     key_pins
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // signed 16-bit distance of a sample from its reference
    function automatic logic signed [15:0] sdelta(input logic [15:0] value, input logic [15:0] ref_level);
        sdelta = $signed(value - ref_level);
    endfunction

    // on-duration limit in clocks for a mode, zero meaning no limit
    function automatic logic [31:0] timeout_limit(input tkd_pkg::tkd_mode_type mode);
        case (mode)
            tkd_pkg::TKD_MODE_DC_SHORT:    timeout_limit = TIMEOUT_SHORT;
            tkd_pkg::TKD_MODE_DC_LONG:     timeout_limit = TIMEOUT_LONG;
            tkd_pkg::TKD_MODE_TOGGLE:      timeout_limit = TIMEOUT_SHORT;
            tkd_pkg::TKD_MODE_DC_INFINITE: timeout_limit = 32'h0000_0000;
            default:                       timeout_limit = 32'h0000_0000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tkd_pkg::tkd_state_type st;
    tkd_pkg::tkd_state_type next_st;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------

    // one pass per clock: scheduler, sample, timers, bus, pins
    always_comb
    begin
        logic [2:0]         c;
        logic signed [15:0] d;
        logic [1:0]         next_integ;
        logic               blocked;
        logic               is_toggle;
        logic [31:0]        limit;
        logic [7:0]         ref_idx;
        logic               hit;
        c          = 3'h0;
        d          = 16'sh0000;
        next_integ = 2'h0;
        blocked    = 1'b0;
        is_toggle  = 1'b0;
        limit      = 32'h0000_0000;
        ref_idx    = 8'h00;
        hit        = 1'b0;

        next_st             = st;
        next_st.acq_request = 1'b0;
        next_st.apb.pready  = 1'b0;
        next_st.apb.pslverr = 1'b0;

        // acquisition pacing: a cycle starts only once the previous one is complete,
        // so slow bursts stretch the cycle and with it every sample-based timing
        if (st.acq_timer != 32'h0000_0000)
        begin
            next_st.acq_timer = st.acq_timer - 32'h0000_0001;
        end
        else if (&st.rx_mask)
        begin
            next_st.acq_request  = 1'b1;
            next_st.rx_mask      = '0;
            next_st.acq_timer    = ACQ_CYCLE - 32'h0000_0001;
            // straps are latched once per cycle and are global to all channels
            next_st.mode         = tkd_pkg::tkd_mode_type'({straps.mode_strap_a, straps.mode_strap_b});
            next_st.drive_open   = straps.drive_type_strap;
            next_st.strongest_en = straps.strongest_key_strap;
        end

        is_toggle = (st.mode == tkd_pkg::TKD_MODE_TOGGLE);

        // one sample of one channel
        if (sample.valid && (sample.chan < 3'(tkd_pkg::NUM_CH)))
        begin
            c = sample.chan;
            d = sdelta(sample.value, st.ref_level[c]);
            next_st.rx_mask[c] = 1'b1;
            next_st.delta[c]   = d;
            if (st.cal_pending[c])
            begin
                // recalibration: reference snaps to the signal
                next_st.ref_level[c]   = sample.value;
                next_st.delta[c]       = 16'h0000;
                next_st.integ[c]       = 2'h0;
                next_st.drift_cnt[c]   = 8'h00;
                next_st.on_timer[c]    = 32'h0000_0000;
                next_st.detected[c]    = 1'b0;
                next_st.cal_pending[c] = 1'b0;
            end
            else if (st.detected[c])
            begin
                // reference stays frozen while the detection holds
                if (d < tkd_pkg::RELEASE_LEVEL)
                begin
                    next_st.detected[c] = 1'b0;
                    next_st.integ[c]    = 2'h0;
                    next_st.on_timer[c] = 32'h0000_0000;
                    if (!is_toggle)
                    begin
                        next_st.out_state[c] = 1'b0;
                    end
                end
            end
            else if (d >= tkd_pkg::THRESHOLD)
            begin
                // above threshold: no drift, integrator counts
                next_st.drift_cnt[c] = 8'h00;
                next_integ = (st.integ[c] == tkd_pkg::INTEG_LIMIT) ? st.integ[c] : st.integ[c] + 2'h1;
                next_st.integ[c] = next_integ;
                if (next_integ == tkd_pkg::INTEG_LIMIT)
                begin
                    // a key that is active, or pending with more signal, blocks this one
                    blocked = 1'b0;
                    if (st.strongest_en)
                    begin
                        for (int j = 0; j < tkd_pkg::NUM_CH; j++)
                        begin
                            if ((3'(j) != c) &&
                                (st.detected[j] ||
                                 ((st.integ[j] != 2'h0) && ($signed(st.delta[j]) > d))))
                            begin
                                blocked = 1'b1;
                            end
                        end
                    end
                    // a blocked key stays pending at the limit and fires once free
                    if (!blocked)
                    begin
                        next_st.detected[c] = 1'b1;
                        next_st.on_timer[c] = 32'h0000_0000;
                        if (is_toggle)
                        begin
                            next_st.out_state[c] = ~st.out_state[c];
                        end
                        else
                        begin
                            next_st.out_state[c] = 1'b1;
                        end
                    end
                end
            end
            else
            begin
                // quiet sample: integrator clears, reference drifts slowly
                next_st.integ[c] = 2'h0;
                if (d < 16'sh0000)
                begin
                    if (st.drift_cnt[c] + 8'h01 >= tkd_pkg::DRIFT_DOWN_SAMPLES)
                    begin
                        next_st.ref_level[c] = st.ref_level[c] - 16'h0001;
                        next_st.drift_cnt[c] = 8'h00;
                    end
                    else
                    begin
                        next_st.drift_cnt[c] = st.drift_cnt[c] + 8'h01;
                    end
                end
                else if (d > 16'sh0000)
                begin
                    if (st.drift_cnt[c] + 8'h01 >= tkd_pkg::DRIFT_UP_SAMPLES)
                    begin
                        next_st.ref_level[c] = st.ref_level[c] + 16'h0001;
                        next_st.drift_cnt[c] = 8'h00;
                    end
                    else
                    begin
                        next_st.drift_cnt[c] = st.drift_cnt[c] + 8'h01;
                    end
                end
                else
                begin
                    next_st.drift_cnt[c] = 8'h00;
                end
            end
        end

        // per-channel on-duration timers, counted in plain clocks
        limit = timeout_limit(st.mode);
        for (int i = 0; i < tkd_pkg::NUM_CH; i++)
        begin
            if (st.detected[i] && (limit != 32'h0000_0000))
            begin
                if (st.on_timer[i] >= limit - 32'h0000_0001)
                begin
                    next_st.detected[i]    = 1'b0;
                    next_st.integ[i]       = 2'h0;
                    next_st.on_timer[i]    = 32'h0000_0000;
                    next_st.cal_pending[i] = 1'b1;
                    if (!is_toggle)
                    begin
                        next_st.out_state[i] = 1'b0;
                    end
                end
                else
                begin
                    next_st.on_timer[i] = st.on_timer[i] + 32'h0000_0001;
                end
            end
        end

        // apb access phase: one wait state, answer registered
        if (apb_req.psel && apb_req.penable && !st.apb.pready)
        begin
            next_st.apb.pready = 1'b1;
            next_st.apb.prdata = 32'h0000_0000;
            hit = 1'b1;
            ref_idx = apb_req.paddr - tkd_pkg::ADDR_REF_BASE;
            case (apb_req.paddr)
                tkd_pkg::ADDR_CTRL:
                begin
                    next_st.apb.prdata[tkd_pkg::NUM_CH-1:0] = st.cal_pending;
                end
                tkd_pkg::ADDR_STATUS:
                begin
                    next_st.apb.prdata[tkd_pkg::NUM_CH-1:0] = st.detected;
                    next_st.apb.prdata[tkd_pkg::STATUS_OUT_LSB +: tkd_pkg::NUM_CH] = st.out_state;
                    next_st.apb.prdata[tkd_pkg::STATUS_RX_LSB +: tkd_pkg::NUM_CH]  = st.rx_mask;
                end
                tkd_pkg::ADDR_OPTS:
                begin
                    next_st.apb.prdata[tkd_pkg::OPTS_MODE_LSB +: 2] = st.mode;
                    next_st.apb.prdata[tkd_pkg::OPTS_DRIVE_BIT]     = st.drive_open;
                    next_st.apb.prdata[tkd_pkg::OPTS_STRONG_BIT]    = st.strongest_en;
                end
                default:
                begin
                    // reference words; anything else answers with an error
                    if ((apb_req.paddr >= tkd_pkg::ADDR_REF_BASE) && (apb_req.paddr <= tkd_pkg::ADDR_REF_LAST) &&
                        (apb_req.paddr[1:0] == 2'h0))
                    begin
                        next_st.apb.prdata[15:0] = st.ref_level[ref_idx[4:2]];
                    end
                    else
                    begin
                        hit = 1'b0;
                    end
                end
            endcase
            next_st.apb.pslverr = ~hit;
        end

        // writes land at the edge that completes the transfer; applied last so set wins over clear
        if (apb_req.psel && apb_req.penable && st.apb.pready && apb_req.pwrite &&
            (apb_req.paddr == tkd_pkg::ADDR_CTRL))
        begin
            next_st.cal_pending = next_st.cal_pending | apb_req.pwdata[tkd_pkg::NUM_CH-1:0];
        end

        // output stage: push-pull active high, or open-drain pulling low when active
        for (int k = 0; k < tkd_pkg::NUM_CH; k++)
        begin
            if (next_st.drive_open)
            begin
                next_st.pins.level[k] = 1'b0;
                next_st.pins.oe[k]    = next_st.out_state[k];
            end
            else
            begin
                next_st.pins.level[k] = next_st.out_state[k];
                next_st.pins.oe[k]    = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // reset recalibrates every channel; pins float until the first clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st             <= '0;
            st.mode        <= tkd_pkg::TKD_MODE_DC_INFINITE;
            st.cal_pending <= tkd_pkg::RST_CAL_PENDING;
            st.rx_mask     <= tkd_pkg::RST_RX_MASK;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------------
    assign apb_rsp     = st.apb;
    assign acq_request = st.acq_request;
    assign key_pins    = st.pins;

endmodule

`default_nettype wire

// [tkd_fe_model.sv]
// front end model: one sample per channel after each acquisition request
`default_nettype none

module tkd_fe_model
(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // request and raw levels to report
    input  wire logic                    acq_request,
    input  wire logic [4:0][15:0]        vals,
    // sample stream
    output var  tkd_pkg::tkd_sample_type sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] idx;

    // ----------------------------------------
    // sample sequencer
    // ----------------------------------------
    // idle value lines invert so stale data never looks valid
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx    <= 3'h0;
            sample <= '0;
        end
        else if (acq_request || (idx != 3'h0 && idx < 3'h5))
        begin
            sample <= '{1'h1, acq_request ? 3'h0 : idx, vals[acq_request ? 3'h0 : idx]};
            idx    <= acq_request ? 3'h1 : idx + 3'h1;
        end
        else
        begin
            idx    <= 3'h0;
            sample <= '{1'h0, 3'h7, ~sample.value};
        end
    end
endmodule

`default_nettype wire

// [tkd_sva.sv]
// port checker for the touch key detection logic
`default_nettype none

module tkd_sva
(
    // clock and reset
    input wire logic                     pclk,
    input wire logic                     presetn,
    // watched ports
    input wire tkd_pkg::tkd_apb_req_type apb_req,
    input wire tkd_pkg::tkd_apb_rsp_type apb_rsp,
    input wire logic                     acq_request,
    input wire tkd_pkg::tkd_sample_type  sample,
    input wire tkd_pkg::tkd_strap_type   straps,
    input wire tkd_pkg::tkd_pin_type     key_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    a_ready_wait: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
        else $error("no answer after one wait state");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    a_err_clean: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
        else $error("error answer malformed");
    a_rdata_hold: assert property (!apb_rsp.pready |-> $stable(apb_rsp.prdata))
        else $error("read data moved without answer");

    // ----------------------------------------
    // acquisition and pins
    // ----------------------------------------
    a_acq_gap: assert property (acq_request |=> (!acq_request)[*8])
        else $error("acquisition requests too close");
    a_drive_form: assert property (key_pins.level == 5'h00 || key_pins.oe == 5'h1F)
        else $error("pin drive form broken");
    a_level_cause: assert property ((key_pins.level & ~$past(key_pins.level)) != 5'h00 |->
        $past(sample.valid) || acq_request)
        else $error("output rose without a sample");
    a_oe_cause: assert property ((key_pins.oe & ~$past(key_pins.oe)) != 5'h00 |->
        $past(sample.valid) || acq_request || !$past(presetn))
        else $error("drive enable rose without cause");
endmodule

`default_nettype wire

// [tb_tkd_touch_key_detect.sv]
// self-checking testbench for the touch key detection logic
`default_nettype none

module tb_tkd_touch_key_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     pclk;
    logic                     presetn;
    tkd_pkg::tkd_apb_req_type req;
    tkd_pkg::tkd_apb_rsp_type rsp;
    logic                     acq;
    tkd_pkg::tkd_sample_type  smp;
    tkd_pkg::tkd_strap_type   straps;
    tkd_pkg::tkd_pin_type     pins;
    logic [4:0][15:0]         vals;
    logic [31:0]              q;
    logic                     err;
    int                       failures;
    int                       check_count;

    // small counts keep the run short
    tkd_touch_key_detect #(.TIMEOUT_SHORT(32'h000000C8), .TIMEOUT_LONG(32'h000004B0), .ACQ_CYCLE(32'h00000014))
        u_tkd_touch_key_detect (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .acq_request(acq), .sample(smp), .straps(straps), .key_pins(pins));
    tkd_fe_model u_tkd_fe_model (.pclk(pclk), .presetn(presetn), .acq_request(acq), .vals(vals), .sample(smp));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // ----------------------------------------
    // bench tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    // pready is read at the edge, before that edge's update lands
    task automatic apb(input logic w, input logic [7:0] a);
        int k;
        @(posedge pclk);
        req <= '{1'h1, 1'h0, w, a, 32'h0};
        @(posedge pclk);
        req.penable <= 1'h1;
        for (k = 0; k < 50 && rsp.pready !== 1'h1; k++)
            @(posedge pclk);
        if (k >= 50)
        begin
            failures++;
            conclude();
        end
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a);
        chk(n, e, q & m);
    endtask

    // waits for n requests, then lets all five samples land
    task automatic wait_acq(input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            for (k = 0; k < 100 && acq !== 1'h1; k++)
                @(posedge pclk);
            @(posedge pclk);
            if (k >= 100)
            begin
                failures++;
                conclude();
            end
        end
        repeat (8) @(posedge pclk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        pclk = 1'h0;
        presetn = 1'h0;
        req = '0;
        straps = '{1'h0, 1'h1, 1'h0, 1'h0};
        vals = {5{16'h1000}};
        failures = 0;
        check_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 4; i++)
        begin
            straps <= {i[1], i[0], i[0], i[1]};
            wait_acq(2);
            rd("opts", 8'h08, 32'hF, {28'h0, i[1], i[0], i[1], i[0]});
            chk("pins", i[0] ? 32'h0 : 32'h1F, {22'h0, pins});
        end
        straps <= '{1'h0, 1'h1, 1'h0, 1'h0};
        apb(1'h0, 8'h0C);
        chk("slverr", 32'h1, {31'h0, err});
        rd("ref0", 8'h10, 32'hFFFF, 32'h1000);
        $display("test options done");
        vals[2] <= 16'h0FFF;
        vals[3] <= 16'h1001;
        wait_acq(4);
        rd("ref2", 8'h18, 32'hFFFF, 32'h0FFF);
        rd("ref3", 8'h1C, 32'hFFFF, 32'h1000);
        $display("test drift done");
        vals[0] <= 16'h1006;
        vals[1] <= 16'h1005;
        wait_acq(2);
        rd("status", 8'h04, 32'h1F1F, 32'h0);
        wait_acq(1);
        rd("status", 8'h04, 32'h1F1F, 32'h0101);
        chk("pins", 32'h3F, {22'h0, pins});
        vals[0] <= 16'h1004;
        wait_acq(1);
        rd("status", 8'h04, 32'h1F1F, 32'h0101);
        rd("ref0", 8'h10, 32'hFFFF, 32'h1000);
        vals[0] <= 16'h1003;
        wait_acq(1);
        rd("status", 8'h04, 32'h1F1F, 32'h0);
        $display("test threshold done");
        vals[0] <= 16'h1010;
        wait_acq(3);
        rd("status", 8'h04, 32'h1F1F, 32'h0101);
        wait_acq(11);
        rd("status", 8'h04, 32'h1F1F, 32'h0);
        rd("ref0", 8'h10, 32'hFFFF, 32'h1010);
        $display("test timeout done");
        straps <= '{1'h1, 1'h1, 1'h0, 1'h0};
        vals[4] <= 16'h1010;
        wait_acq(4);
        rd("status", 8'h04, 32'h1F1F, 32'h1010);
        vals[4] <= 16'h1000;
        wait_acq(1);
        rd("status", 8'h04, 32'h1F1F, 32'h1000);
        vals[4] <= 16'h1010;
        wait_acq(3);
        rd("status", 8'h04, 32'h1F1F, 32'h0010);
        $display("test toggle done");
        vals[0] <= 16'h1020;
        presetn <= 1'h0;
        repeat (125) @(posedge pclk);
        presetn <= 1'h1;
        wait_acq(1);
        rd("ref0", 8'h10, 32'hFFFF, 32'h1020);
        $display("test recalibration done");
        conclude();
    end
endmodule

bind tkd_touch_key_detect tkd_sva u_tkd_sva (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .acq_request(acq_request), .sample(sample), .straps(straps), .key_pins(key_pins));

`default_nettype wire
